// ===== include/rpc_pkg.sv
// Constants shared by the reset pin control block and its synchroniser.
// Assumes a single core clock; all times are counted in clock phase units.
package rpc_pkg;

  // ==========================================================================
  // Timing
  // Core clock period and the length of one clock phase unit
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PHASE_UNIT_PS = 25000;
  // Internal reset sequence length, in clock phase units
  localparam int SEQ_UNITS = 1024;
  // Delay from pull-down release to sampling the filtered input
  localparam int SAMPLE_UNITS = 8;
  // Derived cycle counts, never below one cycle
  localparam int SEQ_CYC_I = (SEQ_UNITS * PHASE_UNIT_PS) / CLK_PERIOD_PS;
  localparam int SAMPLE_CYC_I = (SAMPLE_UNITS * PHASE_UNIT_PS) / CLK_PERIOD_PS;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] SEQ_CYC = CNT_W'((SEQ_CYC_I < 1) ? 1 : SEQ_CYC_I);
  localparam logic [CNT_W-1:0] SAMPLE_CYC =
    CNT_W'((SAMPLE_CYC_I < 1) ? 1 : SAMPLE_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

  // ==========================================================================
  // Reset values
  // Idle level of the reset input pin as seen by the synchroniser
  localparam logic PIN_IDLE = 1'h1;
  // Level the open-drain output drives when enabled
  localparam logic PIN_LOW = 1'h0;

  // ==========================================================================
  // Reset flag patterns {poweron, long hw, short hw, software, watchdog}
  localparam logic [4:0] FLAGS_POR = 5'h1e;
  localparam logic [4:0] FLAGS_LONG = 5'h0e;
  localparam logic [4:0] FLAGS_SHORT = 5'h06;
  localparam logic [4:0] FLAGS_SW = 5'h02;
  localparam logic [4:0] FLAGS_WDT = 5'h01;

  // ==========================================================================
  // Sequencer states, Gray coded along run, sequence, sample
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SEQ = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_HOLD = 3'h2,
    ST_ASYNC = 3'h6
  } rpc_state_e;

  // Cause of the reset sequence in progress
  typedef enum logic [2:0] {
    SRC_POR = 3'h0,
    SRC_HW_SHORT = 3'h1,
    SRC_HW_LONG = 3'h2,
    SRC_HW_ASYNC = 3'h3,
    SRC_SW = 3'h4,
    SRC_WDT = 3'h5
  } rpc_src_e;

endpackage

// ===== rtl/rpc_reset_ctrl.sv
// Reset pin control: reset sequencer, pin drivers and reset source flags.
// Assumes pin levels arrive as plain inputs; the pad resolves open-drain
// output from resetInPinO and resetInPinOe. arst_n is the power-on reset.
//
// Notes on behaviour
// - Bidir enabled: pull reset input during sequence.
// - Reset output low until end-of-init executes.
// - Powerdown config set: pull-up on at end.
// - Reset input low, powerdown pin low: async.
// - Powerdown pin pull-down follows low reset input.
// - Short pulse with powerdown pin high: synchronous.
// - Input held until powerdown pin low: async.
// - Power-on sets flags 1,1,1,1 and watchdog 0.
// - Bidir bit writable before init end, cleared.
// - Sample filtered input eight units after release.
`timescale 1ns/1ps

module rpc_reset_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic resetInPinI,
  output logic resetInPinO,
  output logic resetInPinOe,
  input wire logic rpdPinI,
  output logic rpdPullDownEn,
  output logic rpdPullUpEn,
  output logic resetOutPin,
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic endOfInitExec,
  input wire logic cfgWrEn,
  input wire logic cfgBidirResetEnable,
  input wire logic cfgPowerdownConfig,
  output logic bidirResetEnable,
  output logic powerdownConfigBit,
  output logic internalResetActive,
  output logic asyncResetActive,
  output logic poweronResetFlag,
  output logic longHwResetFlag,
  output logic shortHwResetFlag,
  output logic softwareResetFlag,
  output logic watchdogResetFlag
);

  rpc_pkg::rpc_state_e state_q;
  rpc_pkg::rpc_src_e src_q;
  logic [rpc_pkg::CNT_W-1:0] cnt_q;
  logic [4:0] flags_q;
  logic bidirEn_q;
  logic bidirSeq_q;
  logic powerdown_config_bit_q;
  logic initDone_q;
  logic resetOut_q;
  logic pullUpArm_q;
  logic filtRst;
  logic srcIsSync;
  logic asyncGo;
  logic hwSyncGo;
  logic seqEnd;
  logic sampleEnd;
  logic seqStart;
  logic endOfReset;

  // ==========================================================================
  // Input conditioning
  // Reset input synchronised before any sequencer decision; the powerdown pin pulls use the raw pin
  rpc_sync2 u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn(resetInPinI),
    .syncOut(filtRst)
  );

  // ==========================================================================
  // Reset decisions
  // Software and watchdog sequences ignore our own pulled-down input
  assign srcIsSync = (src_q == rpc_pkg::SRC_SW) || (src_q == rpc_pkg::SRC_WDT);
  // Input low with powerdown pin low means asynchronous hardware reset
  assign asyncGo = !filtRst && !rpdPinI && (state_q != rpc_pkg::ST_ASYNC)
    && !((state_q == rpc_pkg::ST_SEQ) && srcIsSync);
  // Input low with powerdown pin high starts a synchronous reset
  assign hwSyncGo = !filtRst && rpdPinI && (state_q == rpc_pkg::ST_RUN);
  assign seqEnd = (state_q == rpc_pkg::ST_SEQ) && (cnt_q == rpc_pkg::CNT_ONE);
  assign sampleEnd = (state_q == rpc_pkg::ST_SAMPLE) && (cnt_q == rpc_pkg::CNT_ONE);
  // Any new sequence entered from run state
  assign seqStart = (state_q == rpc_pkg::ST_RUN)
    && (hwSyncGo || swResetReq || wdtResetReq);
  // Return to run state closes the reset sequence
  assign endOfReset = (state_q != rpc_pkg::ST_RUN) && (state_q != rpc_pkg::ST_ASYNC)
    && (((state_q == rpc_pkg::ST_SEQ) && seqEnd && !bidirSeq_q
         && (srcIsSync || filtRst))
      || (sampleEnd && filtRst)
      || ((state_q == rpc_pkg::ST_HOLD) && filtRst))
    && !asyncGo;

  // ==========================================================================
  // Sequencer state, source and counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= rpc_pkg::ST_SEQ;
      src_q <= rpc_pkg::SRC_POR;
      cnt_q <= rpc_pkg::SEQ_CYC;
    end else if (asyncGo) begin
      state_q <= rpc_pkg::ST_ASYNC;
      src_q <= rpc_pkg::SRC_HW_ASYNC;
      cnt_q <= rpc_pkg::CNT_ZERO;
    end else begin
      unique case (state_q)
        rpc_pkg::ST_RUN: begin
          if (hwSyncGo) begin
            state_q <= rpc_pkg::ST_SEQ;
            src_q <= rpc_pkg::SRC_HW_SHORT;
            cnt_q <= rpc_pkg::SEQ_CYC;
          end else if (swResetReq || wdtResetReq) begin
            state_q <= rpc_pkg::ST_SEQ;
            src_q <= swResetReq ? rpc_pkg::SRC_SW : rpc_pkg::SRC_WDT;
            cnt_q <= rpc_pkg::SEQ_CYC;
          end
        end
        rpc_pkg::ST_SEQ: begin
          if (seqEnd) begin
            if (bidirSeq_q) begin
              state_q <= rpc_pkg::ST_SAMPLE;
              cnt_q <= rpc_pkg::SAMPLE_CYC;
            end else if (!srcIsSync && !filtRst) begin
              state_q <= rpc_pkg::ST_HOLD;
              src_q <= rpc_pkg::SRC_HW_LONG;
            end else begin
              state_q <= rpc_pkg::ST_RUN;
            end
          end else begin
            cnt_q <= cnt_q - rpc_pkg::CNT_ONE;
          end
        end
        rpc_pkg::ST_SAMPLE: begin
          if (sampleEnd) begin
            if (filtRst) begin
              state_q <= rpc_pkg::ST_RUN;
            end else if (srcIsSync) begin
              state_q <= rpc_pkg::ST_SEQ;
              src_q <= rpc_pkg::SRC_HW_SHORT;
              cnt_q <= rpc_pkg::SEQ_CYC;
            end else begin
              state_q <= rpc_pkg::ST_HOLD;
              src_q <= rpc_pkg::SRC_HW_LONG;
            end
          end else begin
            cnt_q <= cnt_q - rpc_pkg::CNT_ONE;
          end
        end
        rpc_pkg::ST_HOLD: begin
          if (filtRst) begin
            state_q <= rpc_pkg::ST_RUN;
          end
        end
        rpc_pkg::ST_ASYNC: begin
          // Full internal sequence restarts once the input returns high
          if (filtRst) begin
            state_q <= rpc_pkg::ST_SEQ;
            cnt_q <= rpc_pkg::SEQ_CYC;
          end
        end
        default: begin
          state_q <= rpc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================================
  // Reset source flags, overwritten by the latest reset cause
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= rpc_pkg::FLAGS_POR;
    end else if (asyncGo) begin
      flags_q <= rpc_pkg::FLAGS_LONG;
    end else if (hwSyncGo) begin
      flags_q <= rpc_pkg::FLAGS_SHORT;
    end else if (seqStart) begin
      flags_q <= swResetReq ? rpc_pkg::FLAGS_SW : rpc_pkg::FLAGS_WDT;
    end else if (sampleEnd && !filtRst) begin
      // Late low input masks the earlier cause
      flags_q <= srcIsSync ? rpc_pkg::FLAGS_SHORT : rpc_pkg::FLAGS_LONG;
    end else if (seqEnd && !bidirSeq_q && !srcIsSync && !filtRst) begin
      flags_q <= rpc_pkg::FLAGS_LONG;
    end
  end

  // ==========================================================================
  // Configuration bits; bidir bit locked after end of init
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bidirEn_q <= 1'h0;
      bidirSeq_q <= 1'h0;
    end else if (asyncGo) begin
      bidirEn_q <= 1'h0;
      bidirSeq_q <= 1'h0;
    end else if (seqStart) begin
      bidirSeq_q <= bidirEn_q;
      bidirEn_q <= 1'h0;
    end else if ((state_q == rpc_pkg::ST_SAMPLE) || (state_q == rpc_pkg::ST_HOLD)) begin
      bidirSeq_q <= 1'h0;
    end else if (cfgWrEn && !initDone_q && (state_q == rpc_pkg::ST_RUN)) begin
      bidirEn_q <= cfgBidirResetEnable;
    end
  end

  // Powerdown config bit, kept across reset sequences
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerdown_config_bit_q <= 1'h0;
    end else if (cfgWrEn && (state_q == rpc_pkg::ST_RUN)) begin
      powerdown_config_bit_q <= cfgPowerdownConfig;
    end
  end

  // ==========================================================================
  // Reset output: low from any reset until end-of-init executes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resetOut_q <= 1'h0;
      initDone_q <= 1'h0;
    end else if (asyncGo || seqStart) begin
      resetOut_q <= 1'h0;
      initDone_q <= 1'h0;
    end else if (endOfInitExec && (state_q == rpc_pkg::ST_RUN)) begin
      resetOut_q <= 1'h1;
      initDone_q <= 1'h1;
    end
  end

  // ==========================================================================
  // Powerdown pin pull-up, armed at the end of each reset sequence
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pullUpArm_q <= 1'h0;
    end else if (asyncGo || seqStart) begin
      pullUpArm_q <= 1'h0;
    end else if (endOfReset) begin
      pullUpArm_q <= powerdown_config_bit_q;
    end
  end

  // ==========================================================================
  // Pin drivers
  // Open-drain pull-down while a bidirectional sequence runs; released
  // at once if the powerdown pin falls during a software or watchdog one
  assign resetInPinO = rpc_pkg::PIN_LOW;
  assign resetInPinOe = bidirSeq_q && (state_q == rpc_pkg::ST_SEQ)
    && (!srcIsSync || rpdPinI);
  // Weak pull-down discharges the powerdown capacitor while input is low
  assign rpdPullDownEn = !resetInPinI;
  assign rpdPullUpEn = pullUpArm_q && resetInPinI;
  assign resetOutPin = resetOut_q;

  // ==========================================================================
  // Status outputs
  assign bidirResetEnable = bidirEn_q;
  assign powerdownConfigBit = powerdown_config_bit_q;
  assign internalResetActive = (state_q != rpc_pkg::ST_RUN);
  assign asyncResetActive = (state_q == rpc_pkg::ST_ASYNC);
  assign poweronResetFlag = flags_q[4];
  assign longHwResetFlag = flags_q[3];
  assign shortHwResetFlag = flags_q[2];
  assign softwareResetFlag = flags_q[1];
  assign watchdogResetFlag = flags_q[0];

endmodule

// ===== rtl/rpc_sync2.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps

module rpc_sync2 (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_q;
  logic sync_q;

  // ==========================================================================
  // Synchroniser chain; first stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= rpc_pkg::PIN_IDLE;
      sync_q <= rpc_pkg::PIN_IDLE;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule

// ===== sim/rpc_ext_circuit.sv
// External reset circuit: pulled-up reset input with a switch, RC on powerdown pin.
// Assumes the block's open-drain enable and pull controls as plain inputs.
`timescale 1ns/1ps

module rpc_ext_circuit #(
  parameter int CAP_MAX = 3000
) (
  input wire logic core_clk,
  input wire logic extRstReq,
  input wire logic resetInPinO,
  input wire logic resetInPinOe,
  input wire logic rpdPullDownEn,
  input wire logic rpdPullUpEn,
  output logic resetInPin,
  output logic rpdPin
);
  int capLevel = 0;

  // Wired reset input: pull-up, device open drain, external switch
  assign resetInPin = (resetInPinOe ? resetInPinO : 1'h1) & !extRstReq;
  // Capacitor reads high above half charge
  assign rpdPin = (capLevel > CAP_MAX / 2);

  // Capacitor discharged by the pull-down, charged by R0 and the pull-up
  always_ff @(posedge core_clk) begin
    if (rpdPullDownEn) begin
      capLevel <= (capLevel > 0) ? capLevel - 1 : 0;
    end else begin
      capLevel <= (capLevel < CAP_MAX) ? capLevel + (rpdPullUpEn ? 6 : 4) : CAP_MAX;
    end
  end
endmodule

// ===== sim/rpc_reset_ctrl_props.sv
// Concurrent checks on the ports of the reset pin control block.
// Assumes one core clock and the active-low asynchronous power-on reset.
`timescale 1ns/1ps

module rpc_reset_ctrl_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic resetInPinI,
  input wire logic resetInPinOe,
  input wire logic rpdPinI,
  input wire logic rpdPullDownEn,
  input wire logic rpdPullUpEn,
  input wire logic resetOutPin,
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic endOfInitExec,
  input wire logic bidirResetEnable,
  input wire logic powerdownConfigBit,
  input wire logic internalResetActive,
  input wire logic asyncResetActive,
  input wire logic poweronResetFlag,
  input wire logic longHwResetFlag,
  input wire logic shortHwResetFlag,
  input wire logic softwareResetFlag,
  input wire logic watchdogResetFlag
);
  // ==========================================================================
  // Shared clocking and the flag vector
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic [4:0] resetFlags = {poweronResetFlag, longHwResetFlag, shortHwResetFlag,
    softwareResetFlag, watchdogResetFlag};

  // ==========================================================================
  // Pin and flag relations
  chk_pulldown_follows_pin: assert property (rpdPullDownEn == !resetInPinI)
    else $error("powerdown pull-down does not follow reset input");
  chk_reset_output_pin_after_end_of_init_instruction: assert property ($rose(resetOutPin) |-> $past(endOfInitExec))
    else $error("reset output released without end of init");
  chk_reset_output_pin_low_seq: assert property (internalResetActive |-> !resetOutPin)
    else $error("reset output high during a sequence");
  chk_bidir_pull_start: assert property (!internalResetActive && swResetReq &&
    bidirResetEnable && rpdPinI |=> resetInPinOe)
    else $error("no pull-down on reset input after software reset");
  chk_pull_in_seq: assert property (resetInPinOe |-> internalResetActive && rpdPinI)
    else $error("reset input pulled outside a sequence");
  chk_bidir_cleared: assert property ($rose(internalResetActive) |-> !bidirResetEnable)
    else $error("bidir enable survives a reset");
  chk_por_flags: assert property ($rose(arst_n) |-> resetFlags == rpc_pkg::FLAGS_POR)
    else $error("power-on flag pattern wrong");
  chk_sync_two_stages: assert property (!internalResetActive && $fell(resetInPinI) &&
    !swResetReq && !wdtResetReq |=> !internalResetActive)
    else $error("reset input acted on without synchroniser delay");
  chk_async_entry: assert property ($rose(asyncResetActive) |-> !rpdPinI &&
    resetFlags == rpc_pkg::FLAGS_LONG)
    else $error("async reset entered wrongly");
  chk_pullup_cond: assert property (rpdPullUpEn |-> powerdownConfigBit && resetInPinI)
    else $error("powerdown pull-up on without its config");
endmodule

bind rpc_reset_ctrl rpc_reset_ctrl_props u_rpc_reset_ctrl_props (
  .core_clk(core_clk), .arst_n(arst_n), .resetInPinI(resetInPinI),
  .resetInPinOe(resetInPinOe), .rpdPinI(rpdPinI), .rpdPullDownEn(rpdPullDownEn),
  .rpdPullUpEn(rpdPullUpEn), .resetOutPin(resetOutPin), .swResetReq(swResetReq),
  .wdtResetReq(wdtResetReq), .endOfInitExec(endOfInitExec),
  .bidirResetEnable(bidirResetEnable), .powerdownConfigBit(powerdownConfigBit),
  .internalResetActive(internalResetActive), .asyncResetActive(asyncResetActive),
  .poweronResetFlag(poweronResetFlag), .longHwResetFlag(longHwResetFlag),
  .shortHwResetFlag(shortHwResetFlag), .softwareResetFlag(softwareResetFlag),
  .watchdogResetFlag(watchdogResetFlag)
);

// ===== sim/rpc_reset_ctrl_tb.sv
// Self-checking bench for the reset pin control block.
// Assumes the external circuit model and the bound property checker.
`timescale 1ns/1ps

module rpc_reset_ctrl_tb;
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic extRstReq = 1'h0;
  logic swResetReq = 1'h0;
  logic wdtResetReq = 1'h0;
  logic endOfInitExec = 1'h0;
  logic cfgWrEn = 1'h0;
  logic cfgBidirResetEnable = 1'h0;
  logic cfgPowerdownConfig = 1'h0;
  logic resetInPinI, resetInPinO, resetInPinOe, rpdPinI, rpdPullDownEn, rpdPullUpEn;
  logic resetOutPin, bidirResetEnable, powerdownConfigBit, internalResetActive;
  logic asyncResetActive, poweronResetFlag, longHwResetFlag, shortHwResetFlag;
  logic softwareResetFlag, watchdogResetFlag;
  logic [4:0] flags;
  int failures = 0;
  int checks = 0;

  // ==========================================================================
  // Clock, design and far side
  always #12.5 core_clk = ~core_clk;
  assign flags = {poweronResetFlag, longHwResetFlag, shortHwResetFlag, softwareResetFlag,
    watchdogResetFlag};

  rpc_reset_ctrl u_rpc_reset_ctrl (.core_clk(core_clk), .arst_n(arst_n),
    .resetInPinI(resetInPinI), .resetInPinO(resetInPinO), .resetInPinOe(resetInPinOe),
    .rpdPinI(rpdPinI), .rpdPullDownEn(rpdPullDownEn), .rpdPullUpEn(rpdPullUpEn),
    .resetOutPin(resetOutPin), .swResetReq(swResetReq), .wdtResetReq(wdtResetReq),
    .endOfInitExec(endOfInitExec), .cfgWrEn(cfgWrEn),
    .cfgBidirResetEnable(cfgBidirResetEnable), .cfgPowerdownConfig(cfgPowerdownConfig),
    .bidirResetEnable(bidirResetEnable), .powerdownConfigBit(powerdownConfigBit),
    .internalResetActive(internalResetActive), .asyncResetActive(asyncResetActive),
    .poweronResetFlag(poweronResetFlag), .longHwResetFlag(longHwResetFlag),
    .shortHwResetFlag(shortHwResetFlag), .softwareResetFlag(softwareResetFlag),
    .watchdogResetFlag(watchdogResetFlag));

  rpc_ext_circuit u_rpc_ext_circuit (.core_clk(core_clk), .extRstReq(extRstReq),
    .resetInPinO(resetInPinO), .resetInPinOe(resetInPinOe),
    .rpdPullDownEn(rpdPullDownEn), .rpdPullUpEn(rpdPullUpEn),
    .resetInPin(resetInPinI), .rpdPin(rpdPinI));

  // ==========================================================================
  // Access and compare tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // One-cycle strobe: 0 software, 1 watchdog, 2 end of init, 3 config write
  // Only the chosen strobe is raised and lowered, so calls may follow back to back
  task automatic strobe(input int which);
    case (which)
      0: swResetReq = 1'h1;
      1: wdtResetReq = 1'h1;
      2: endOfInitExec = 1'h1;
      default: cfgWrEn = 1'h1;
    endcase
    tick(1);
    case (which)
      0: swResetReq = 1'h0;
      1: wdtResetReq = 1'h0;
      2: endOfInitExec = 1'h0;
      default: cfgWrEn = 1'h0;
    endcase
  endtask

  task automatic cmpFlags(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    cmpFlags({4'h0, got}, {4'h0, exp});
  endtask

  // Bounded wait: 0 sequence active, 1 async hold active
  task automatic waitSig(input int which, input logic exp, input int maxCyc);
    int n;
    n = 0;
    while (((which == 0) ? internalResetActive : asyncResetActive) !== exp && n < maxCyc) begin
      tick(1);
      n++;
    end
    cmpBit((which == 0) ? internalResetActive : asyncResetActive, exp);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Hang guard
  initial begin
    #1000000;
    failures++;
    end_of_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    tick(8);
    arst_n = 1'h1;
    cmpFlags(flags, 5'h1e);
    cmpBit(resetOutPin, 1'h0);
    waitSig(0, 1'h0, 1200);
    $display("test poweron done");
    cfgBidirResetEnable = 1'h1;
    cfgPowerdownConfig = 1'h1;
    strobe(3);
    cmpBit(bidirResetEnable, 1'h1);
    cmpBit(powerdownConfigBit, 1'h1);
    strobe(0);
    cmpBit(resetInPinOe, 1'h1);
    cmpBit(resetInPinO, 1'h0);
    cmpBit(rpdPullDownEn, 1'h1);
    cmpBit(bidirResetEnable, 1'h0);
    cmpFlags(flags, 5'h02);
    waitSig(0, 1'h0, 1200);
    cmpFlags(flags, 5'h02);
    cmpBit(rpdPullUpEn, 1'h1);
    $display("test bidir software done");
    strobe(1);
    cmpBit(resetInPinOe, 1'h0);
    cmpFlags(flags, 5'h01);
    waitSig(0, 1'h0, 1200);
    $display("test watchdog done");
    // Pulse seen only after the two synchroniser stages
    extRstReq = 1'h1;
    tick(2);
    cmpBit(internalResetActive, 1'h0);
    tick(2);
    extRstReq = 1'h0;
    waitSig(0, 1'h1, 4);
    cmpFlags(flags, 5'h06);
    cmpBit(resetOutPin, 1'h0);
    waitSig(0, 1'h0, 1200);
    $display("test short hardware done");
    extRstReq = 1'h1;
    waitSig(1, 1'h1, 2000);
    cmpFlags(flags, 5'h0e);
    extRstReq = 1'h0;
    waitSig(0, 1'h0, 1500);
    $display("test async done");
    // Input held low past the sample point turns a watchdog reset into a hardware one
    strobe(3);
    cmpBit(bidirResetEnable, 1'h1);
    strobe(1);
    cmpBit(resetInPinOe, 1'h1);
    extRstReq = 1'h1;
    tick(1040);
    cmpFlags(flags, rpc_pkg::FLAGS_SHORT);
    cmpBit(internalResetActive, 1'h1);
    extRstReq = 1'h0;
    waitSig(0, 1'h0, 1200);
    cmpFlags(flags, rpc_pkg::FLAGS_SHORT);
    $display("test bidir degeneration done");
    strobe(2);
    cmpBit(resetOutPin, 1'h1);
    strobe(3);
    cmpBit(bidirResetEnable, 1'h0);
    $display("test end of init done");
    end_of_test();
  end
endmodule
